/* File: src/iba_pkg.sv */
/*
  Shared constants and types for the isolated bitstream acquisition block.
  Assumes one 40 MHz system clock and a word-aligned register port.

*/
package iba_pkg;
  localparam int MCLK_HZ = 40_000_000;
  localparam int MOD_MIN_HZ = 5_000_000;
  localparam int MOD_MAX_HZ = 20_000_000;
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] DIV_MIN =
    DIV_W'((MCLK_HZ + MOD_MAX_HZ - 1) / MOD_MAX_HZ);
  localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(MCLK_HZ / MOD_MIN_HZ);
  localparam int SAR_HZ = 4_000_000;
  localparam logic [3:0] SAR_DIV_LAST = 4'(MCLK_HZ / SAR_HZ - 1);
  localparam logic [3:0] SAR_SMP_LAST = 4'(8 - 1);
  localparam logic [3:0] SAR_CNV_LAST = 4'(12 - 1);
  localparam int SAR_NCH = 16;
  localparam logic [3:0] SAR_CH_LAST = 4'(SAR_NCH - 1);
  localparam int CH_TEMP = 10;
  localparam int CH_V1 = 5;
  localparam int NPH = 3;
  localparam int RES_W = 10;
  localparam int WORD_W = 16;
  localparam int VACC_W = 48;
  localparam int PACC_W = 64;
  localparam int CNT_W = 16;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DIV = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_MASK = 8'h0C;
  localparam logic [7:0] A_COUNT = 8'h10;
  localparam logic [7:0] A_CUR0 = 8'h14;
  localparam logic [7:0] A_CUR_END = 8'h20;
  localparam logic [7:0] A_SAR = 8'h40;
  localparam logic [7:0] A_FRM = 8'h80;
  localparam int C_RUN = 0;
  localparam int C_FMT = 1;
  localparam int ST_SAMPLE = 0;
  localparam int ST_TRIG = 1;
  localparam int ST_SCAN = 2;
  localparam int ST_FRAME = 3;
  localparam int NST = 4;

  typedef struct packed {
    logic [VACC_W-1:0] vv;
    logic [PACC_W-1:0] ii;
    logic [PACC_W-1:0] pp;
    logic [PACC_W-1:0] qq;
  } iba_acc_t;

  typedef struct packed {
    logic sample;
    logic convert;
    logic [3:0] channel;
  } iba_sar_ctl_t;

  typedef enum {S_IDLE, S_SAMP, S_CONV} iba_sar_st_t;
endpackage

/* File: src/iba_acquisition.sv */
/*
  Three-phase acquisition front end: modulation clock divider, three
  bitstream decimators with a shared trigger, a scanning SAR sequencer,
  per-sample product accumulation into frames and a register port.
  Assumes synchronous bitstream inputs and a SAR analog core whose result
  is valid by the last convert cycle of each channel.
*/
`timescale 1ns/1ps
module iba_acquisition #(
  parameter int OVERSAMPLING_RATIO = 1024,
  parameter int FRAME_CYCLES = 50,
  parameter int QDLY = 25
) (
  input wire logic mclk, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wdata, // register write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  output logic irq, // level interrupt
  output logic mod_clk_out, // modulation clock to modulators
  input wire logic bitstream_in_0, // phase A modulator stream
  input wire logic bitstream_in_1, // phase B modulator stream
  input wire logic bitstream_in_2, // phase C modulator stream
  output iba_pkg::iba_sar_ctl_t sar_ctl, // SAR core sequencing
  input wire logic [iba_pkg::RES_W-1:0] sar_result // SAR core result
);
  import iba_pkg::*;

  localparam int CW = $clog2(OVERSAMPLING_RATIO) + 1;
  localparam int QW = $clog2(QDLY);
  localparam int FW = $clog2(FRAME_CYCLES + 1);

  logic run, fmt;
  logic [DIV_W-1:0] div, div_act, div_cnt, next_div_cnt;
  logic mod_tick, dec_end, dec_pulse;
  logic [CW-1:0] dec_cnt;
  logic [CW-1:0] ones [NPH];
  logic signed [WORD_W-1:0] cur [NPH];
  logic [NPH-1:0] bits;
  logic [3:0] sdiv, sar_ch, sar_cyc;
  logic sar_tick, start_pend, scan_done;
  iba_sar_st_t sar_st;
  logic [RES_W-1:0] res [SAR_NCH];
  iba_acc_t acc [NPH];
  iba_acc_t frm [NPH];
  logic signed [WORD_W-1:0] qline [NPH][QDLY];
  logic [QW-1:0] qptr;
  logic signed [WORD_W-1:0] v1;
  logic prev_neg, zc, frame_end;
  logic [FW-1:0] cyc_cnt;
  logic [CNT_W-1:0] scnt, frame_cnt;
  logic [NST-1:0] status, mask, ev, next_status;
  logic [31:0] rmux;

  // Ones count to signed word: count minus half the ratio, left-justified.
  function automatic logic signed [WORD_W-1:0] to_cur(
    input logic [CW-1:0] c);
    logic signed [CW:0] s;
    s = $signed({1'b0, c}) - $signed((CW+1)'(OVERSAMPLING_RATIO / 2));
    return WORD_W'(s) <<< (WORD_W - CW);
  endfunction

  // Offset binary to left-justified two's complement when signed is set.
  function automatic logic [WORD_W-1:0] fmt_res(
    input logic [RES_W-1:0] r, input logic signed_fmt);
    if (signed_fmt) begin
      return {~r[RES_W-1], r[RES_W-2:0], (WORD_W-RES_W)'(0)};
    end else begin
      return {(WORD_W-RES_W)'(0), r};
    end
  endfunction

  function automatic logic [31:0] frm_word(
    input iba_acc_t a, input logic [2:0] w);
    case (w)
      3'h0: return a.vv[31:0];
      3'h1: return {(64-VACC_W)'(0), a.vv[VACC_W-1:32]};
      3'h2: return a.ii[31:0];
      3'h3: return a.ii[63:32];
      3'h4: return a.pp[31:0];
      3'h5: return a.pp[63:32];
      3'h6: return a.qq[31:0];
      default: return a.qq[63:32];
    endcase
  endfunction

  // Register writes. Out-of-range divider values are dropped whole.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      run <= 1'b0;
      fmt <= 1'b0;
      div <= DIV_MAX;
      mask <= '0;
    end else if (wr) begin
      case (addr)
        A_CTRL: begin
          run <= wdata[C_RUN];
          fmt <= wdata[C_FMT];
        end
        A_DIV: begin
          if (wdata >= 32'(DIV_MIN) && wdata <= 32'(DIV_MAX)) begin
            div <= wdata[DIV_W-1:0];
          end
        end
        A_MASK: mask <= wdata[NST-1:0];
        default: ;
      endcase
    end
  end

  // The modulation clock runs from reset regardless of the group enable,
  // so the modulators are settled by the time the filters start.
  always_comb begin
    mod_tick = (div_cnt >= div_act - 1'b1);
    next_div_cnt = mod_tick ? '0 : div_cnt + 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      div_cnt <= '0;
      div_act <= DIV_MAX;
      mod_clk_out <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      if (mod_tick) begin
        div_act <= div;
      end
      mod_clk_out <= (next_div_cnt < (div_act >> 1));
    end
  end

  // Streams are taken on the system edge that raises the output clock.
  assign bits = {bitstream_in_2, bitstream_in_1, bitstream_in_0};
  assign dec_end = run & mod_tick & (dec_cnt == CW'(OVERSAMPLING_RATIO - 1));

  always_ff @(posedge mclk) begin
    if (!nrst || !run) begin
      dec_cnt <= '0;
    end else if (mod_tick) begin
      dec_cnt <= dec_end ? '0 : dec_cnt + 1'b1;
    end
  end

  for (genvar g = 0; g < NPH; g++) begin : g_filt
    always_ff @(posedge mclk) begin
      if (!nrst) begin
        ones[g] <= '0;
        cur[g] <= '0;
      end else if (!run) begin
        ones[g] <= '0;
      end else if (mod_tick) begin
        if (dec_end) begin
          cur[g] <= to_cur(ones[g] + CW'(bits[g]));
          ones[g] <= '0;
        end else begin
          ones[g] <= ones[g] + CW'(bits[g]);
        end
      end
    end
  end

  // One pulse serves as both the sample-ready and the trigger event.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      dec_pulse <= 1'b0;
    end else begin
      dec_pulse <= dec_end;
    end
  end

  assign sar_tick = (sdiv == SAR_DIV_LAST);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sdiv <= '0;
    end else begin
      sdiv <= sar_tick ? '0 : sdiv + 1'b1;
    end
  end

  // A trigger that lands mid-scan is held and starts the next scan.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      start_pend <= 1'b0;
    end else begin
      start_pend <= dec_pulse |
        (start_pend & ~(sar_tick & (sar_st == S_IDLE)));
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sar_st <= S_IDLE;
      sar_ch <= '0;
      sar_cyc <= '0;
      scan_done <= 1'b0;
    end else begin
      scan_done <= 1'b0;
      if (sar_tick) begin
        case (sar_st)
          S_IDLE: begin
            if (start_pend) begin
              sar_st <= S_SAMP;
              sar_ch <= '0;
              sar_cyc <= '0;
            end
          end
          S_SAMP: begin
            if (sar_cyc == SAR_SMP_LAST) begin
              sar_st <= S_CONV;
              sar_cyc <= '0;
            end else begin
              sar_cyc <= sar_cyc + 1'b1;
            end
          end
          S_CONV: begin
            if (sar_cyc == SAR_CNV_LAST) begin
              sar_cyc <= '0;
              if (sar_ch == SAR_CH_LAST) begin
                sar_st <= S_IDLE;
                scan_done <= 1'b1;
              end else begin
                sar_st <= S_SAMP;
                sar_ch <= sar_ch + 1'b1;
              end
            end else begin
              sar_cyc <= sar_cyc + 1'b1;
            end
          end
          default: sar_st <= S_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < SAR_NCH; i++) begin
        res[i] <= '0;
      end
    end else if (sar_tick && sar_st == S_CONV && sar_cyc == SAR_CNV_LAST) begin
      res[sar_ch] <= sar_result;
    end
  end

  // Core controls lag the sequencer state by one system clock.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sar_ctl <= '0;
    end else begin
      sar_ctl.sample <= (sar_st == S_SAMP);
      sar_ctl.convert <= (sar_st == S_CONV);
      sar_ctl.channel <= sar_ch;
    end
  end

  // Frames close on a rising zero crossing of the first phase voltage.
  assign v1 = $signed(fmt_res(res[CH_V1], 1'b1));
  assign zc = prev_neg & ~v1[WORD_W-1];
  assign frame_end = scan_done & zc &
    (cyc_cnt == FW'(FRAME_CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (!nrst || !run) begin
      prev_neg <= 1'b0;
      cyc_cnt <= '0;
      scnt <= '0;
    end else if (scan_done) begin
      prev_neg <= v1[WORD_W-1];
      scnt <= frame_end ? '0 : scnt + 1'b1;
      if (zc) begin
        cyc_cnt <= frame_end ? '0 : cyc_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      frame_cnt <= '0;
    end else if (frame_end) begin
      frame_cnt <= scnt + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      qptr <= '0;
    end else if (scan_done) begin
      qptr <= (qptr == QW'(QDLY - 1)) ? '0 : qptr + 1'b1;
    end
  end

  // Reactive products use the voltage delayed by about a quarter cycle;
  // the fixed depth trades accuracy off-nominal for a small delay line.
  for (genvar g = 0; g < NPH; g++) begin : g_acc
    logic signed [WORD_W-1:0] v, v90, ic;
    logic signed [2*WORD_W-1:0] pvv, pii, ppp, pqq;
    iba_acc_t nx;

    assign v = $signed(fmt_res(res[CH_V1 - g], 1'b1));
    assign v90 = qline[g][qptr];
    assign ic = cur[g];
    assign pvv = v * v;
    assign pii = ic * ic;
    assign ppp = v * ic;
    assign pqq = v90 * ic;

    always_comb begin
      nx.vv = acc[g].vv + VACC_W'(pvv);
      nx.ii = acc[g].ii + PACC_W'(pii);
      nx.pp = acc[g].pp + PACC_W'(ppp);
      nx.qq = acc[g].qq + PACC_W'(pqq);
    end

    always_ff @(posedge mclk) begin
      if (!nrst) begin
        acc[g] <= '0;
        frm[g] <= '0;
      end else if (!run) begin
        acc[g] <= '0;
      end else if (scan_done) begin
        if (frame_end) begin
          frm[g] <= nx;
          acc[g] <= '0;
        end else begin
          acc[g] <= nx;
        end
      end
    end

    always_ff @(posedge mclk) begin
      if (!nrst) begin
        for (int i = 0; i < QDLY; i++) begin
          qline[g][i] <= '0;
        end
      end else if (scan_done) begin
        qline[g][qptr] <= v;
      end
    end
  end

  // Events set sticky bits; a set in the clearing read's cycle survives.
  always_comb begin
    ev = '0;
    ev[ST_SAMPLE] = dec_pulse;
    ev[ST_TRIG] = dec_pulse;
    ev[ST_SCAN] = scan_done;
    ev[ST_FRAME] = frame_end;
    next_status = ((rd && addr == A_STAT) ? '0 : status) | ev;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      status <= '0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= |(next_status & mask);
    end
  end

  always_comb begin
    logic [7:0] off;
    off = '0;
    rmux = '0;
    if (addr == A_CTRL) begin
      rmux[C_RUN] = run;
      rmux[C_FMT] = fmt;
    end else if (addr == A_DIV) begin
      rmux[DIV_W-1:0] = div;
    end else if (addr == A_STAT) begin
      rmux[NST-1:0] = status;
    end else if (addr == A_MASK) begin
      rmux[NST-1:0] = mask;
    end else if (addr == A_COUNT) begin
      rmux[CNT_W-1:0] = frame_cnt;
    end else if (addr >= A_CUR0 && addr < A_CUR_END) begin
      off = addr - A_CUR0;
      rmux = 32'(cur[off[3:2]]);
    end else if (addr >= A_SAR && addr < A_FRM) begin
      rmux[WORD_W-1:0] = fmt_res(res[addr[5:2]], fmt);
    end else if (addr >= A_FRM) begin
      off = addr - A_FRM;
      if (off[6:5] < 2'(NPH)) begin
        rmux = frm_word(frm[off[6:5]], off[4:2]);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata <= '0;
    end else begin
      rdata <= rd ? rmux : '0;
    end
  end
endmodule

/* File: bench/iba_acquisition_checker.sv */
/*
  Concurrent checks on the acquisition block, bound to its top module.
  Assumes the package's 10-cycle SAR tick and the 2..8 divider range.
*/
`timescale 1ns/1ps
module iba_acquisition_checker (
  input wire logic mclk, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [31:0] rdata, // read data
  input wire logic irq, // level interrupt
  input wire logic mod_clk_out, // modulation clock
  input wire iba_pkg::iba_sar_ctl_t sar_ctl // SAR sequencing
);
  import iba_pkg::*;
  logic [7:0] smp_n;
  logic [7:0] cnv_n;
  logic [15:0] gap;
  logic smp_d;
  logic start_c;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  assign start_c = sar_ctl.sample && !smp_d && sar_ctl.channel == 4'h0;
  // Phase lengths are too long for a repetition, so they are counted.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      smp_n <= 8'h00;
      cnv_n <= 8'h00;
    end else begin
      smp_n <= sar_ctl.sample ? smp_n + 8'h01 : 8'h00;
      cnv_n <= sar_ctl.convert ? cnv_n + 8'h01 : 8'h00;
    end
  end
  // The gap starts saturated so that the first scan after reset passes.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      smp_d <= 1'b0;
      gap <= 16'hFFFF;
    end else begin
      smp_d <= sar_ctl.sample;
      if (start_c) gap <= 16'h0001;
      else if (gap != 16'hFFFF) gap <= gap + 16'h0001;
    end
  end
  property p_rd_idle;
    !rd |=> rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_mck_high;
    $rose(mod_clk_out) |-> ##[1:4] $fell(mod_clk_out);
  endproperty
  a_mck_high: assert property (p_mck_high) else $error("clock high");
  // The low phase lasts at most eight cycles, even when the divider is rewritten.
  property p_mck_low;
    $fell(mod_clk_out) |-> ##[1:8] $rose(mod_clk_out);
  endproperty
  a_mck_low: assert property (p_mck_low) else $error("clock low");
  property p_excl;
    !(sar_ctl.sample && sar_ctl.convert);
  endproperty
  a_excl: assert property (p_excl) else $error("sample and convert");
  property p_smp_len;
    $fell(sar_ctl.sample) |-> smp_n == 8'h50;
  endproperty
  a_smp_len: assert property (p_smp_len) else $error("sample length");
  property p_cnv_len;
    $fell(sar_ctl.convert) |-> cnv_n == 8'h78;
  endproperty
  a_cnv_len: assert property (p_cnv_len) else $error("convert length");
  property p_ch_step;
    $rose(sar_ctl.sample) |-> sar_ctl.channel == 4'h0 ||
      sar_ctl.channel == $past(sar_ctl.channel) + 4'h1;
  endproperty
  a_ch_step: assert property (p_ch_step) else $error("channel order");
  property p_scan_gap;
    start_c |-> gap >= 16'hC80;
  endproperty
  a_scan_gap: assert property (p_scan_gap) else $error("scan overlap");
  property p_irq_fall;
    $fell(irq) |-> $past(rd || wr) || $past(rd || wr, 2) ||
      $past(rd || wr, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
  c_scan: cover property (start_c);
  c_irq: cover property ($rose(irq));
  c_read: cover property (rd ##1 rdata != 32'h0);
endmodule

bind iba_acquisition iba_acquisition_checker i_chk (.mclk(mclk),
  .nrst(nrst), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
  .mod_clk_out(mod_clk_out), .sar_ctl(sar_ctl));

/* File: bench/iba_modulator_model.sv */
/*
  Behavioural model of the three external isolated modulators.
  Assumes the block samples each stream where the modulation clock rises.
*/
`timescale 1ns/1ps
module iba_modulator_model #(
  parameter logic [11:0] DENS = 12'h48C // ones per 16 bits, per stream
) (
  input wire logic mod_clk_out, // modulation clock from the block
  output logic bitstream_in_0, // phase A stream
  output logic bitstream_in_1, // phase B stream
  output logic bitstream_in_2 // phase C stream
);
  logic [3:0] acc [3] = '{4'h0, 4'h0, 4'h0};
  logic [2:0] bits = 3'b000;
  assign bitstream_in_0 = bits[0];
  assign bitstream_in_1 = bits[1];
  assign bitstream_in_2 = bits[2];
  // Bits move on the falling edge so they are settled where the block
  // samples them; the first-order pattern repeats every 16 bits.
  always @(negedge mod_clk_out) begin
    for (int k = 0; k < 3; k++) begin
      {bits[k], acc[k]} <= {1'b0, acc[k]} + {1'b0, DENS[4*k +: 4]};
    end
  end
endmodule

/* File: bench/tb_iba_acquisition.sv */
/*
  Testbench for the acquisition block: register tasks, a SAR result source
  and one task per scenario. Assumes the modulator model and the checker.
*/
`timescale 1ns/1ps
module tb_iba_acquisition;
  import iba_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic irq;
  logic mck;
  logic [2:0] bs;
  logic par = 1'b0;
  logic smp_d = 1'b0;
  iba_sar_ctl_t sar_ctl;
  logic [RES_W-1:0] sar_result = 10'h000;
  int n_mismatch = 0;
  int compares = 0;

  always #12.5 mclk = ~mclk;

  iba_acquisition #(.OVERSAMPLING_RATIO(512), .FRAME_CYCLES(2), .QDLY(2)) i_dut (
    .mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .mod_clk_out(mck),
    .bitstream_in_0(bs[0]), .bitstream_in_1(bs[1]),
    .bitstream_in_2(bs[2]), .sar_ctl(sar_ctl), .sar_result(sar_result));

  iba_modulator_model i_mod (.mod_clk_out(mck), .bitstream_in_0(bs[0]),
    .bitstream_in_1(bs[1]), .bitstream_in_2(bs[2]));

  // Phase-1 voltage flips sign every scan, so it rises through zero every second one.
  always @(posedge mclk) begin
    if (sar_ctl.sample && !smp_d && sar_ctl.channel == 4'h0) par <= ~par;
    smp_d <= sar_ctl.sample;
    sar_result <= (sar_ctl.channel == 4'h5) ? (par ? 10'h300 : 10'h100) :
      {sar_ctl.channel, 6'h15};
  end

  task automatic conclude();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    d = rdata;
  endtask

  task automatic poll(input int b);
    q = 32'h0;
    for (int i = 0; i < 15000 && q[b] !== 1'b1; i++) rreg(A_STAT, q);
    chk({31'h0, q[b]}, 32'h1);
    if (q[b] !== 1'b1) conclude();
  endtask

  task automatic tgl(input int exp);
    int n;
    logic m;
    n = 0;
    m = mck;
    repeat (16) begin
      @(posedge mclk);
      n += int'(mck != m);
      m = mck;
    end
    chk(32'(n), 32'(exp));
  endtask

  task automatic t_div();
    rreg(A_DIV, q);
    chk(q, 32'h8);
    tgl(4);
    wreg(A_DIV, 32'h9);
    wreg(A_DIV, 32'h1);
    rreg(A_DIV, q);
    chk(q, 32'h8);
    wreg(A_DIV, 32'h2);
    repeat (8) @(posedge mclk);
    tgl(16);
    wreg(A_DIV, 32'h8);
    rreg(8'hFC, q);
    chk(q, 32'h0);
  endtask

  task automatic t_idle();
    repeat (5000) @(posedge mclk);
    rreg(A_STAT, q);
    chk(q & 32'h7, 32'h0);
  endtask

  task automatic t_irq();
    wreg(A_MASK, 32'h1);
    wreg(A_CTRL, 32'h1);
    for (int i = 0; i < 6000 && irq !== 1'b1; i++) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    if (irq !== 1'b1) conclude();
    rreg(A_STAT, q);
    chk(q & 32'h3, 32'h3);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    rreg(A_CUR0, q);
    // Densities 12/16 and 4/16 over 512 bits give +128 and -128 ones.
    chk(q, 32'h0000_2000);
    rreg(A_CUR0 + 8'h4, q);
    chk(q, 32'h0);
    rreg(A_CUR0 + 8'h8, q);
    chk(q, 32'hFFFF_E000);
    wreg(A_MASK, 32'h0);
    repeat (5000) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    rreg(A_STAT, q);
    chk(q & 32'h3, 32'h3);
  endtask

  task automatic t_scan();
    poll(2);
    for (int c = 0; c < 16; c++) begin
      rreg(A_SAR + 8'(4 * c), q);
      if (c != 5) chk(q, {22'h0, 4'(c), 6'h15});
    end
    wreg(A_CTRL, 32'h3);
    rreg(A_SAR + 8'h28, q);
    chk({16'h0, q[15:0]}, {16'h0, 1'b0, 9'h095, 6'h00});
  endtask

  task automatic t_frame();
    poll(3);
    poll(3);
    rreg(A_COUNT, q);
    chk(q, 32'h4);
    rreg(A_FRM, q);
    chk(q, 32'h4000_0000);
    rreg(A_FRM + 8'h04, q);
    chk(q, 32'h0);
    rreg(A_FRM + 8'h10, q);
    chk(q, 32'h0);
    rreg(A_FRM + 8'h28, q);
    chk(q, 32'h0);
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_div();
    t_idle();
    t_irq();
    t_scan();
    t_frame();
    conclude();
  end
endmodule
